/* File: logic/cec_top.sv */
// The register addresses and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "cec_defs.svh"
module cec_top #(
  parameter int ADDR_W      = 8,
  parameter int SYNC_STAGES = 2
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              cmp_raw_in,
  output logic                   latched_cmp_out,
  output logic                   raw_cmp_out,
  output logic                   cmp_power_en,
  output cec_pkg::cec_hyst_e     pos_hyst_sel,
  output cec_pkg::cec_hyst_e     neg_hyst_sel,
  output cec_pkg::cec_mode_e     resp_mode,
  output logic                   irq,
  output logic                   cmp_reset_req
);

  // Offsets widened once to the address bus width
  localparam logic [ADDR_W-1:0] ADR_CTRL  = ADDR_W'(`CEC_OFS_CTRL);
  localparam logic [ADDR_W-1:0] ADR_RESP  = ADDR_W'(`CEC_OFS_RESP);
  localparam logic [ADDR_W-1:0] ADR_MASK  = ADDR_W'(`CEC_OFS_MASK);
  localparam logic [ADDR_W-1:0] ADR_RSTEN = ADDR_W'(`CEC_OFS_RSTEN);

  // Address must reach the highest register; refused at elaboration
  if (ADDR_W < 4) begin
    $error("cec_top needs an address of at least four bits");
  end

  // A single flop would leave the edge detectors open to metastability
  if (SYNC_STAGES < 2) begin
    $error("cec_top needs at least two synchroniser stages");
  end

  // Bus slave state
  cec_pkg::cec_bus_e   bus_reg;
  cec_pkg::cec_bus_e   bus_next;
  logic                ack_reg;
  logic                ack_next;
  logic [31:0]         dat_reg;
  logic [31:0]         dat_next;

  // Software-visible registers
  cec_pkg::cec_ctrl_s  ctrl_reg;
  cec_pkg::cec_ctrl_s  ctrl_next;
  cec_pkg::cec_mode_e  mode_reg;
  cec_pkg::cec_mode_e  mode_next;
  cec_pkg::cec_flags_s flags_reg;
  cec_pkg::cec_flags_s flags_next;
  cec_pkg::cec_flags_s mask_reg;
  cec_pkg::cec_flags_s mask_next;
  logic                rsten_reg;
  logic                rsten_next;

  // Edge detector state
  logic                prev_reg;
  logic                prev_next;
  logic                armed_reg;
  logic                armed_next;

  // Registered outputs
  logic                latched_reg;
  logic                latched_next;
  logic                power_reg;
  logic                power_next;
  cec_pkg::cec_hyst_e  hyp_reg;
  cec_pkg::cec_hyst_e  hyp_next;
  cec_pkg::cec_hyst_e  hyn_reg;
  cec_pkg::cec_hyst_e  hyn_next;
  cec_pkg::cec_mode_e  mode_out_reg;
  cec_pkg::cec_mode_e  mode_out_next;
  logic                irq_reg;
  logic                irq_next;
  logic                rstreq_reg;
  logic                rstreq_next;

  // Decoded strobes and derived levels
  logic                req;
  logic                wr_commit;
  logic                level_sync;
  logic                level;
  logic                rise_evt;
  logic                fall_evt;
  cec_pkg::cec_flags_s clr;

  // Address hits and per-register write strobes
  logic                hit_ctrl;
  logic                hit_resp;
  logic                hit_mask;
  logic                hit_rsten;
  logic                wr_ctrl;
  logic                wr_resp;
  logic                wr_mask;
  logic                wr_rsten;

  cec_sync #(
    .STAGES   (SYNC_STAGES)
  ) u_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in (cmp_raw_in),
    .sync_out (level_sync)
  );

  assign level = level_sync & ctrl_reg.enable;

  // Request and the edge at which a write lands
  assign req       = wb_cyc_i & wb_stb_i;
  assign wr_commit = req & wb_we_i & ack_reg & wb_sel_i[`CEC_LANE];

  // Address decode shared by the read mux and the write strobes
  assign hit_ctrl  = (wb_adr_i == ADR_CTRL);
  assign hit_resp  = (wb_adr_i == ADR_RESP);
  assign hit_mask  = (wb_adr_i == ADR_MASK);
  assign hit_rsten = (wb_adr_i == ADR_RSTEN);

  // Write strobes; lane select and ack edge already folded in
  assign wr_ctrl   = wr_commit & hit_ctrl;
  assign wr_resp   = wr_commit & hit_resp;
  assign wr_mask   = wr_commit & hit_mask;
  assign wr_rsten  = wr_commit & hit_rsten;

  // Bus handshake: one ack per request, dropped the cycle after
  always_comb begin
    bus_next = bus_reg;
    ack_next = 1'b0;
    case (bus_reg)
      cec_pkg::CEC_BUS_IDLE: begin
        if (req) begin
          bus_next = cec_pkg::CEC_BUS_ACK;
          ack_next = 1'b1;
        end
      end
      cec_pkg::CEC_BUS_ACK: begin
        bus_next = cec_pkg::CEC_BUS_IDLE;
      end
      default: begin
        bus_next = cec_pkg::CEC_BUS_IDLE;
      end
    endcase
  end

  // Read data captured with ack; unmapped reads as zero
  always_comb begin
    dat_next = `CEC_DATA_RST;
    if (bus_reg == cec_pkg::CEC_BUS_IDLE && req && !wb_we_i) begin
      if (hit_ctrl) begin
        dat_next[`CEC_B_EN]                 = ctrl_reg.enable;
        dat_next[`CEC_B_LVL]                = level;
        dat_next[`CEC_B_RISE]               = flags_reg.rise;
        dat_next[`CEC_B_FALL]               = flags_reg.fall;
        dat_next[`CEC_HYP_HI:`CEC_HYP_LO]   = ctrl_reg.pos_hyst;
        dat_next[`CEC_HYN_HI:`CEC_HYN_LO]   = ctrl_reg.neg_hyst;
      end else if (hit_resp) begin
        dat_next[`CEC_MODE_HI:`CEC_MODE_LO] = mode_reg;
      end else if (hit_mask) begin
        dat_next[`CEC_B_RISE]               = mask_reg.rise;
        dat_next[`CEC_B_FALL]               = mask_reg.fall;
      end else if (hit_rsten) begin
        dat_next[`CEC_B_RSTEN]              = rsten_reg;
      end
    end
  end

  // Bus registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bus_reg <= cec_pkg::CEC_BUS_IDLE;
      ack_reg <= 1'b0;
      dat_reg <= `CEC_DATA_RST;
    end else begin
      bus_reg <= bus_next;
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  // Configuration writes; only the low byte lane holds fields
  always_comb begin
    ctrl_next  = ctrl_reg;
    mode_next  = mode_reg;
    mask_next  = mask_reg;
    rsten_next = rsten_reg;
    clr        = '0;
    if (wr_ctrl) begin
      ctrl_next.enable   = wb_dat_i[`CEC_B_EN];
      ctrl_next.pos_hyst = cec_pkg::cec_hyst_e'(wb_dat_i[`CEC_HYP_HI:`CEC_HYP_LO]);
      ctrl_next.neg_hyst = cec_pkg::cec_hyst_e'(wb_dat_i[`CEC_HYN_HI:`CEC_HYN_LO]);
      // Writing one clears a flag, zero leaves it
      clr.rise           = wb_dat_i[`CEC_B_RISE];
      clr.fall           = wb_dat_i[`CEC_B_FALL];
    end
    if (wr_resp) begin
      mode_next = cec_pkg::cec_mode_e'(wb_dat_i[`CEC_MODE_HI:`CEC_MODE_LO]);
    end
    if (wr_mask) begin
      mask_next.rise = wb_dat_i[`CEC_B_RISE];
      mask_next.fall = wb_dat_i[`CEC_B_FALL];
    end
    if (wr_rsten) begin
      rsten_next = wb_dat_i[`CEC_B_RSTEN];
    end
  end

  // Edge detection on the synchronised value only. Edges are ignored in
  // the first cycle after enable, since the history is stale then;
  // power-up glitches later on are still caught and software clears them.
  always_comb begin
    prev_next  = level_sync;
    armed_next = ctrl_reg.enable;
    rise_evt   = armed_reg & ctrl_reg.enable & level_sync & ~prev_reg;
    fall_evt   = armed_reg & ctrl_reg.enable & ~level_sync & prev_reg;
  end

  // Sticky flags; a new edge beats a clear in the same cycle
  always_comb begin
    flags_next.rise = (flags_reg.rise & ~clr.rise) | rise_evt;
    flags_next.fall = (flags_reg.fall & ~clr.fall) | fall_evt;
  end

  // Software configuration registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_reg.enable   <= `CEC_EN_RST;
      ctrl_reg.pos_hyst <= cec_pkg::CEC_HYST_OFF;
      ctrl_reg.neg_hyst <= cec_pkg::CEC_HYST_OFF;
      mode_reg          <= cec_pkg::CEC_MODE_2;
      mask_reg          <= '0;
      rsten_reg         <= `CEC_RSTEN_RST;
    end else begin
      ctrl_reg          <= ctrl_next;
      mode_reg          <= mode_next;
      mask_reg          <= mask_next;
      rsten_reg         <= rsten_next;
    end
  end

  // Sticky edge flags, kept apart so a clear never disturbs config
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // Edge history; starts disarmed so reset release is not an edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prev_reg  <= `CEC_FLAG_RST;
      armed_reg <= `CEC_FLAG_RST;
    end else begin
      prev_reg  <= prev_next;
      armed_reg <= armed_next;
    end
  end

  // Output stage toward the pins and analog core
  always_comb begin
    latched_next  = level;
    power_next    = ctrl_reg.enable;
    hyp_next      = ctrl_reg.pos_hyst;
    hyn_next      = ctrl_reg.neg_hyst;
    mode_out_next = mode_reg;
    irq_next      = (flags_reg.rise & mask_reg.rise) | (flags_reg.fall & mask_reg.fall);
    rstreq_next   = rsten_reg & ctrl_reg.enable & armed_reg & ~level_sync;
  end

  // Output registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      latched_reg  <= 1'b0;
      power_reg    <= 1'b0;
      hyp_reg      <= cec_pkg::CEC_HYST_OFF;
      hyn_reg      <= cec_pkg::CEC_HYST_OFF;
      mode_out_reg <= cec_pkg::CEC_MODE_2;
      irq_reg      <= 1'b0;
      rstreq_reg   <= 1'b0;
    end else begin
      latched_reg  <= latched_next;
      power_reg    <= power_next;
      hyp_reg      <= hyp_next;
      hyn_reg      <= hyn_next;
      mode_out_reg <= mode_out_next;
      irq_reg      <= irq_next;
      rstreq_reg   <= rstreq_next;
    end
  end

  // Raw path must work with the clock stopped, so it alone is a gate
  // rather than a flop; it is forced low while disabled.
  // raw asynchronous output
  assign raw_cmp_out     = cmp_raw_in & ctrl_reg.enable;

  assign wb_dat_o        = dat_reg;
  assign wb_ack_o        = ack_reg;
  assign latched_cmp_out = latched_reg;
  assign cmp_power_en    = power_reg;
  assign pos_hyst_sel    = hyp_reg;
  assign neg_hyst_sel    = hyn_reg;
  assign resp_mode       = mode_out_reg;
  assign irq             = irq_reg;
  assign cmp_reset_req   = rstreq_reg;

endmodule

/* File: logic/cec_defs.svh */
`ifndef CEC_DEFS_SVH
`define CEC_DEFS_SVH

// Register byte offsets on the register bus
`define CEC_OFS_CTRL   8'h00
`define CEC_OFS_RESP   8'h04
`define CEC_OFS_MASK   8'h08
`define CEC_OFS_RSTEN  8'h0C

// Control register field positions
`define CEC_B_EN       7
`define CEC_B_LVL      6
`define CEC_B_RISE     5
`define CEC_B_FALL     4
`define CEC_HYP_HI     3
`define CEC_HYP_LO     2
`define CEC_HYN_HI     1
`define CEC_HYN_LO     0

// Response and reset-enable field positions
`define CEC_MODE_HI    1
`define CEC_MODE_LO    0
`define CEC_B_RSTEN    0

// Byte lane that carries every register
`define CEC_LANE       0

// Reset values
`define CEC_EN_RST     1'h0
`define CEC_FLAG_RST   1'h0
`define CEC_RSTEN_RST  1'h0
`define CEC_DATA_RST   32'h0000_0000

`endif

/* File: logic/cec_pkg.sv */
package cec_pkg;

  // Hysteresis amount, one field per direction
  typedef enum logic [1:0] {
    CEC_HYST_OFF  = 2'h0,
    CEC_HYST_5MV  = 2'h1,
    CEC_HYST_10MV = 2'h2,
    CEC_HYST_20MV = 2'h3
  } cec_hyst_e;

  // Response mode, fastest and hungriest first
  typedef enum logic [1:0] {
    CEC_MODE_FAST = 2'h0,
    CEC_MODE_1    = 2'h1,
    CEC_MODE_2    = 2'h2,
    CEC_MODE_SLOW = 2'h3
  } cec_mode_e;

  // Bus slave states, one-hot
  typedef enum logic [1:0] {
    CEC_BUS_IDLE = 2'h1,
    CEC_BUS_ACK  = 2'h2
  } cec_bus_e;

  // Writable control fields
  typedef struct packed {
    logic      enable;
    cec_hyst_e pos_hyst;
    cec_hyst_e neg_hyst;
  } cec_ctrl_s;

  // Edge flags, also the interrupt mask layout
  typedef struct packed {
    logic rise;
    logic fall;
  } cec_flags_s;

endpackage

/* File: logic/cec_sync.sv */
`timescale 1ns/1ps
module cec_sync #(
  parameter int STAGES = 2
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic async_in,
  output logic      sync_out
);

  logic [STAGES-1:0] chain_reg;
  logic [STAGES-1:0] chain_next;

  // Refuse a chain too short to settle metastability
  if (STAGES < 2) begin
    $error("cec_sync needs at least two stages");
  end

  // Shift in; first stage feeds only the second
  always_comb begin
    chain_next = {chain_reg[STAGES-2:0], async_in};
  end

  // Chain registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      chain_reg <= '0;
    end else begin
      chain_reg <= chain_next;
    end
  end

  assign sync_out = chain_reg[STAGES-1];

endmodule

/* File: sim/cec_top_checker.sv */
`timescale 1ns/1ps
module cec_top_checker #(
  parameter int ADDR_W = 8
) (
  input wire logic               clock,
  input wire logic               rst,
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_we_i,
  input wire logic [ADDR_W-1:0]  wb_adr_i,
  input wire logic [3:0]         wb_sel_i,
  input wire logic [31:0]        wb_dat_i,
  input wire logic [31:0]        wb_dat_o,
  input wire logic               wb_ack_o,
  input wire logic               cmp_raw_in,
  input wire logic               latched_cmp_out,
  input wire logic               raw_cmp_out,
  input wire logic               cmp_power_en,
  input wire cec_pkg::cec_hyst_e pos_hyst_sel,
  input wire cec_pkg::cec_hyst_e neg_hyst_sel,
  input wire cec_pkg::cec_mode_e resp_mode,
  input wire logic               irq,
  input wire logic               cmp_reset_req
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Two quiet enable samples mean the latched output is low now and the raw output was low one sample earlier
  property p_off; !cmp_power_en ##1 !cmp_power_en |-> !latched_cmp_out && !$past(raw_cmp_out);
  endproperty
  a_off: assert property (p_off) else $error("pin output high while disabled");
  property p_raw; raw_cmp_out |-> cmp_raw_in; endproperty
  a_raw: assert property (p_raw) else $error("raw output high with input low");
  property p_sync; cmp_power_en [*5] |-> latched_cmp_out == $past(cmp_raw_in, 3); endproperty
  a_sync: assert property (p_sync) else $error("latched output off by timing");
  // Irq only rises after a level change or a register write
  property p_irq_up;
    $rose(irq) |-> $past(latched_cmp_out) != $past(latched_cmp_out, 2) ||
      $past(latched_cmp_out, 2) != $past(latched_cmp_out, 3) ||
      $past(wb_ack_o && wb_we_i, 2) || $past(wb_ack_o && wb_we_i, 3);
  endproperty
  a_irq_up: assert property (p_irq_up) else $error("irq rose without edge");
  property p_irq_hold;
    $fell(irq) |-> $past(wb_ack_o && wb_we_i, 2) || $past(wb_ack_o && wb_we_i, 3);
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq fell without write");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than a cycle");
  property p_ack_take; $rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o; endproperty
  a_ack_take: assert property (p_ack_take) else $error("request not acked in time");
  property p_mode_wr; $changed(resp_mode) |-> $past(wb_ack_o && wb_we_i, 1) ||
    $past(wb_ack_o && wb_we_i, 2); endproperty
  a_mode_wr: assert property (p_mode_wr) else $error("mode moved without write");
  property p_hyst_wr; $changed({pos_hyst_sel, neg_hyst_sel}) |-> $past(wb_ack_o && wb_we_i &&
    wb_adr_i == 0, 1) || $past(wb_ack_o && wb_we_i && wb_adr_i == 0, 2); endproperty
  a_hyst_wr: assert property (p_hyst_wr) else $error("hysteresis moved alone");
  property p_rst_req; cmp_reset_req |-> !latched_cmp_out; endproperty
  a_rst_req: assert property (p_rst_req) else $error("reset request with output high");
  c_irq: cover property ($rose(irq));
  c_rreq: cover property ($rose(cmp_reset_req));
  c_wr: cover property (wb_ack_o && wb_we_i);
endmodule
bind cec_top cec_top_checker #(.ADDR_W(ADDR_W)) i_chk (.clock(clock), .rst(rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .cmp_raw_in(cmp_raw_in), .latched_cmp_out(latched_cmp_out), .raw_cmp_out(raw_cmp_out),
  .cmp_power_en(cmp_power_en), .pos_hyst_sel(pos_hyst_sel), .neg_hyst_sel(neg_hyst_sel),
  .resp_mode(resp_mode), .irq(irq), .cmp_reset_req(cmp_reset_req));

/* File: sim/cec_cmp_model.sv */
`timescale 1ns/1ps
module cec_cmp_model (
  input  wire logic               clock,
  input  wire logic               cmp_power_en,
  input  wire cec_pkg::cec_mode_e resp_mode,
  input  wire logic               target,
  output logic                    cmp_raw_in
);
  logic [1:0] wait_cnt = 2'h0;
  initial cmp_raw_in = 1'b0;
  // Unpowered core gives garbage; powered core settles after mode delay
  // slower mode lags
  always @(posedge clock) begin
    if (!cmp_power_en) begin
      cmp_raw_in <= ~cmp_raw_in;
      wait_cnt   <= 2'h0;
    end else if (cmp_raw_in !== target && wait_cnt < resp_mode) begin
      wait_cnt <= wait_cnt + 2'h1;
    end else begin
      cmp_raw_in <= target;
      wait_cnt   <= 2'h0;
    end
  end
endmodule

/* File: sim/tb_comparator_edge_control.sv */
`timescale 1ns/1ps
module tb_comparator_edge_control;
  logic clock = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, wen = 1'b0, target = 1'b0;
  logic [3:0] sel = 4'hF;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic ack, raw_in, latched, raw_out, pwr, irq, rreq;
  cec_pkg::cec_hyst_e hp, hn;
  cec_pkg::cec_mode_e mode;
  int n_errors = 0, check_count = 0;
  always #2 clock = ~clock;
  cec_top i_dut (.clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wen),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .cmp_raw_in(raw_in), .latched_cmp_out(latched), .raw_cmp_out(raw_out),
    .cmp_power_en(pwr), .pos_hyst_sel(hp), .neg_hyst_sel(hn), .resp_mode(mode), .irq(irq),
    .cmp_reset_req(rreq));
  cec_cmp_model i_core (.clock(clock), .cmp_power_en(pwr), .resp_mode(mode),
    .target(target), .cmp_raw_in(raw_in));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One classic cycle, held until ack is sampled; only the watchdog ends a wait
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                    output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    adr <= a;
    wen <= w;
    wdat <= d;
    @(posedge clock);
    while (ack !== 1'b1) begin
      @(posedge clock);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(a, 1'b1, d, q);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(a, 1'b0, 32'h0, q);
    chk(q, e);
  endtask
  // Bounded wait: 0 latched, 1 irq, 2 reset request
  task automatic wt(input int s, input logic v);
    int n;
    n = 0;
    while ((s == 2 ? rreq : s == 1 ? irq : latched) !== v && n < 40) begin
      @(posedge clock);
      n++;
    end
    chk(s == 2 ? rreq : s == 1 ? irq : latched, v);
  endtask
  task automatic t_reset;
    chk({pwr, raw_out, latched, irq, rreq, hp, hn, mode}, 32'h2);
    wr(8'h10, 32'hFF);
    for (int i = 0; i < 5; i++) begin
      rc(8'(i * 4), i == 1 ? 32'h2 : 32'h0);
    end
    $display("t_reset done");
  endtask
  task automatic t_fields;
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, 32'(i * 4 + 3 - i));
      @(posedge clock);
      chk({hp, hn}, 32'(i * 4 + 3 - i));
      wr(8'h04, 32'(i));
      @(posedge clock);
      chk(mode, 32'(i));
      rc(8'h00, 32'(i * 4 + 3 - i));
    end
    sel <= 4'h0;
    wr(8'h00, 32'h0F);
    sel <= 4'hF;
    rc(8'h00, 32'h0C);
    wr(8'h04, 32'h2);
    $display("t_fields done");
  endtask
  task automatic t_edges;
    wr(8'h08, 32'h30);
    wr(8'h00, 32'h80);
    target <= 1'b1;
    // Unpowered core toggles; wait until it has settled
    repeat (10) @(posedge clock);
    wt(0, 1'b1);
    chk(raw_out, 1'b1);
    wr(8'h00, 32'hB0);
    wt(1, 1'b0);
    rc(8'h00, 32'hC0);
    target <= 1'b0;
    wt(1, 1'b1);
    rc(8'h00, 32'h90);
    target <= 1'b1;
    wt(0, 1'b1);
    rc(8'h00, 32'hF0);
    wr(8'h00, 32'h80);
    rc(8'h00, 32'hF0);
    wr(8'h00, 32'hA0);
    rc(8'h00, 32'hD0);
    wr(8'h08, 32'h0);
    wt(1, 1'b0);
    wr(8'h00, 32'hB0);
    $display("t_edges done");
  endtask
  task automatic t_off;
    wr(8'h00, 32'h00);
    @(posedge clock);
    chk({pwr, latched, raw_out}, 32'h0);
    repeat (8) @(posedge clock);
    rc(8'h00, 32'h0);
    $display("t_off done");
  endtask
  task automatic t_rsrc;
    wr(8'h0C, 32'h1);
    rc(8'h0C, 32'h1);
    wr(8'h00, 32'hB0);
    // Let the core settle past power-up garbage
    repeat (10) @(posedge clock);
    chk(rreq, 1'b0);
    target <= 1'b0;
    wt(2, 1'b1);
    target <= 1'b1;
    wt(2, 1'b0);
    wr(8'h0C, 32'h0);
    $display("t_rsrc done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Watchdog far beyond the expected few hundred cycles
  initial begin
    #80000;
    $display("[FAIL] %0t watchdog expired", $time);
    n_errors++;
    end_of_test();
  end
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_fields();
    t_edges();
    t_off();
    t_rsrc();
    end_of_test();
  end
endmodule
